// ### design/esm_cfg.svh
// Purpose: Constants of the slave state machine.
// Assumes: Included by the package and the state machine file.
// Notes: State codes are the ones the master writes and reads back.
`ifndef ESM_CFG_SVH
`define ESM_CFG_SVH
`define ESM_CODE_INIT 4'h1
`define ESM_CODE_PREOP 4'h2
`define ESM_CODE_BOOT 4'h3
`define ESM_CODE_SAFEOP 4'h4
`define ESM_CODE_OP 4'h8
`define ESM_ERR_NONE 4'h0
`define ESM_ERR_ILLEGAL 4'h1
`define ESM_ERR_MBXCFG 4'h2
`define ESM_ERR_PDCFG 4'h3
`define ESM_FW_VER_RESET 16'h0000
`endif

// ### design/esm_pkg.sv
// Purpose: Types of the slave state machine.
// Assumes: esm_cfg.svh holds the codes.
// Notes: None.
`include "esm_cfg.svh"
package esm_pkg;
  typedef enum logic [3:0] {
    ST_INIT   = `ESM_CODE_INIT,
    ST_PREOP  = `ESM_CODE_PREOP,
    ST_BOOT   = `ESM_CODE_BOOT,
    ST_SAFEOP = `ESM_CODE_SAFEOP,
    ST_OP     = `ESM_CODE_OP
  } esm_state_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_COPY = 2'b01
  } esm_phase_t;
endpackage : esm_pkg

// ### design/input_stage.sv
// Purpose: Word memory holding the input image seen by the master.
// Assumes: One clock; read data registered.
// Notes: Written from the live inputs.
`timescale 1ns/10ps
`default_nettype none
module input_stage #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Write side.
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // Read side.
  input  wire logic [AW-1:0]    rdAddr,
  output var  logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdData;

  always_comb
  begin
    next_rdData = mem[rdAddr];
  end

  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdData <= '0;
    end
    else
    begin
      rdData <= next_rdData;
    end
  end
endmodule : input_stage
`default_nettype wire

// ### design/slave_state_machine.sv
// Purpose: Communication state machine of a fieldbus slave coupler.
// Assumes: Master requests come as a one-cycle strobe with a state code.
// Notes: Channel checks arrive as levels from the channel logic.
// How it works
// - After reset the state is Init, code 01h.
// - Init blocks mailbox and process data traffic.
// - Init to Pre-Op (02h) needs a good mailbox channel check.
// - Pre-Op allows mailbox, blocks process data.
// - Pre-Op to Safe-Op (04h) needs a good process channel check.
// - Inputs are copied to the stage before Safe-Op is acknowledged from Pre-Op.
// - Safe-Op allows all traffic, refreshes inputs, outputs stay off.
// - Op (08h) drives outputs from master data, allows all traffic.
// - Bootstrap (03h) is entered only from Init.
// - Bootstrap allows only file-access mailbox, nothing else.
// - Firmware equal to the installed version is not taken.
// - A downloaded image is adopted on return to Init.
`timescale 1ns/10ps
`default_nettype none
`include "esm_cfg.svh"
module slave_state_machine #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset_n,
  // State request from the master.
  input  wire logic             reqValid,
  input  wire logic [3:0]       reqState,
  output var  logic [3:0]       curState,
  output var  logic             ackValid,
  output var  logic             errFlag,
  output var  logic [3:0]       errCode,
  input  wire logic             errClear,
  // Channel set-up checks.
  input  wire logic             mbxCfgOk,
  input  wire logic             pdCfgOk,
  // Traffic gates.
  output var  logic             mbxEnable,
  output var  logic             foeOnly,
  output var  logic             pdEnable,
  // Process data.
  input  wire logic [WIDTH-1:0] inPins,
  input  wire logic [AW-1:0]    inRdAddr,
  output var  logic [WIDTH-1:0] inRdData,
  input  wire logic [WIDTH-1:0] masterOut,
  output var  logic [WIDTH-1:0] outPins,
  // Firmware update.
  input  wire logic             fwDone,
  input  wire logic [15:0]      fwNewVer,
  output var  logic [15:0]      fwVersion,
  output var  logic             fwAdopt
);
  esm_pkg::esm_state_t state, next_state;
  esm_pkg::esm_phase_t phase, next_phase;
  logic [AW-1:0]    copyAddr, next_copyAddr;
  logic             next_ackValid;
  logic             next_errFlag;
  logic [3:0]       next_errCode;
  logic             fwPending, next_fwPending;
  logic [15:0]      fwStaged, next_fwStaged;
  logic [15:0]      next_fwVersion;
  logic             next_fwAdopt;
  logic [WIDTH-1:0] next_outPins;
  logic             stageWr;

  function automatic logic legalStep(input logic [3:0] from,
                                     input logic [3:0] to);
    logic ok;
    ok = 1'b0;
    case (to)
      `ESM_CODE_INIT:   ok = 1'b1;
      `ESM_CODE_PREOP:  ok = (from != `ESM_CODE_BOOT);
      `ESM_CODE_BOOT:   ok = (from == `ESM_CODE_INIT) ||
                             (from == `ESM_CODE_BOOT);
      `ESM_CODE_SAFEOP: ok = (from == `ESM_CODE_PREOP) ||
                             (from == `ESM_CODE_SAFEOP) ||
                             (from == `ESM_CODE_OP);
      `ESM_CODE_OP:     ok = (from == `ESM_CODE_SAFEOP) ||
                             (from == `ESM_CODE_OP);
      default:          ok = 1'b0;
    endcase
    return ok;
  endfunction : legalStep

  always_comb
  begin
    next_state    = state;
    next_phase    = phase;
    next_copyAddr = copyAddr;
    next_ackValid = 1'b0;
    next_errFlag  = errFlag & ~errClear;
    next_errCode  = errCode;
    case (phase)
      esm_pkg::PH_IDLE:
      begin
        if (reqValid)
        begin
          if (!legalStep(state, reqState))
          begin
            next_errFlag  = 1'b1;
            next_errCode  = `ESM_ERR_ILLEGAL;
            next_ackValid = 1'b1;
          end
          else if (reqState == `ESM_CODE_PREOP &&
                   state == esm_pkg::ST_INIT && !mbxCfgOk)
          begin
            next_errFlag  = 1'b1;
            next_errCode  = `ESM_ERR_MBXCFG;
            next_ackValid = 1'b1;
          end
          else if (reqState == `ESM_CODE_SAFEOP &&
                   state == esm_pkg::ST_PREOP && !pdCfgOk)
          begin
            next_errFlag  = 1'b1;
            next_errCode  = `ESM_ERR_PDCFG;
            next_ackValid = 1'b1;
          end
          else if (reqState == `ESM_CODE_SAFEOP &&
                   state == esm_pkg::ST_PREOP)
          begin
            next_phase    = esm_pkg::PH_COPY;
            next_copyAddr = '0;
          end
          else
          begin
            next_state    = esm_pkg::esm_state_t'(reqState);
            next_ackValid = 1'b1;
            next_errCode  = `ESM_ERR_NONE;
          end
        end
      end
      esm_pkg::PH_COPY:
      begin
        next_copyAddr = copyAddr + 1'b1;
        if (copyAddr == AW'(DEPTH - 1))
        begin
          next_phase    = esm_pkg::PH_IDLE;
          next_state    = esm_pkg::ST_SAFEOP;
          next_ackValid = 1'b1;
          next_errCode  = `ESM_ERR_NONE;
        end
      end
      default: next_phase = esm_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state    <= esm_pkg::ST_INIT;
      phase    <= esm_pkg::PH_IDLE;
      copyAddr <= '0;
      ackValid <= 1'b0;
      errFlag  <= 1'b0;
      errCode  <= `ESM_ERR_NONE;
    end
    else
    begin
      state    <= next_state;
      phase    <= next_phase;
      copyAddr <= next_copyAddr;
      ackValid <= next_ackValid;
      errFlag  <= next_errFlag;
      errCode  <= next_errCode;
    end
  end

  assign curState = state;

  // Traffic gates follow the state.
  always_comb
  begin
    mbxEnable = 1'b0;
    foeOnly   = 1'b0;
    pdEnable  = 1'b0;
    case (state)
      esm_pkg::ST_INIT:   mbxEnable = 1'b0;
      esm_pkg::ST_PREOP:  mbxEnable = 1'b1;
      esm_pkg::ST_BOOT:   foeOnly   = 1'b1;
      esm_pkg::ST_SAFEOP:
      begin
        mbxEnable = 1'b1;
        pdEnable  = 1'b1;
      end
      esm_pkg::ST_OP:
      begin
        mbxEnable = 1'b1;
        pdEnable  = 1'b1;
      end
      default: mbxEnable = 1'b0;
    endcase
  end

  // The input stage is filled during the copy and refreshed while live.
  assign stageWr = (phase == esm_pkg::PH_COPY) || pdEnable;

  input_stage #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_stage (
    .clk     (clk),
    .reset_n (reset_n),
    .wrEn    (stageWr),
    .wrAddr  (phase == esm_pkg::PH_COPY ? copyAddr : inRdAddr),
    .wrData  (inPins),
    .rdAddr  (inRdAddr),
    .rdData  (inRdData)
  );

  // Outputs and firmware bookkeeping.
  always_comb
  begin
    next_outPins   = '0;
    next_fwPending = fwPending;
    next_fwStaged  = fwStaged;
    next_fwVersion = fwVersion;
    next_fwAdopt   = 1'b0;
    if (state == esm_pkg::ST_OP)
    begin
      next_outPins = masterOut;
    end
    if (state == esm_pkg::ST_BOOT && fwDone &&
        fwNewVer != fwVersion)
    begin
      next_fwPending = 1'b1;
      next_fwStaged  = fwNewVer;
    end
    if (fwPending && state == esm_pkg::ST_INIT)
    begin
      next_fwPending = 1'b0;
      next_fwVersion = fwStaged;
      next_fwAdopt   = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      outPins   <= '0;
      fwPending <= 1'b0;
      fwStaged  <= `ESM_FW_VER_RESET;
      fwVersion <= `ESM_FW_VER_RESET;
      fwAdopt   <= 1'b0;
    end
    else
    begin
      outPins   <= next_outPins;
      fwPending <= next_fwPending;
      fwStaged  <= next_fwStaged;
      fwVersion <= next_fwVersion;
      fwAdopt   <= next_fwAdopt;
    end
  end

  sequence illegal_req_s;
    reqValid && phase == esm_pkg::PH_IDLE && !legalStep(state, reqState);
  endsequence

  state_after_reset_a: assert property (
    @(posedge clk) $rose(reset_n) |-> state == esm_pkg::ST_INIT)
    else $error("State is not Init after reset.");
  init_blocks_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    state == esm_pkg::ST_INIT |-> !mbxEnable && !pdEnable && !foeOnly)
    else $error("Traffic open in Init.");
  mbx_check_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    reqValid && phase == esm_pkg::PH_IDLE && state == esm_pkg::ST_INIT
    && reqState == `ESM_CODE_PREOP && !mbxCfgOk
    |=> state == esm_pkg::ST_INIT && errFlag)
    else $error("Bad mailbox set-up accepted.");
  preop_gate_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    state == esm_pkg::ST_PREOP |-> mbxEnable && !pdEnable)
    else $error("Wrong gates in Pre-Op.");
  pd_check_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    reqValid && phase == esm_pkg::PH_IDLE && state == esm_pkg::ST_PREOP
    && reqState == `ESM_CODE_SAFEOP && !pdCfgOk
    |=> state == esm_pkg::ST_PREOP && errCode == `ESM_ERR_PDCFG)
    else $error("Bad process set-up accepted.");
  copy_first_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(phase == esm_pkg::PH_COPY) |->
    !ackValid [*8] ##1 state == esm_pkg::ST_SAFEOP && ackValid)
    else $error("Safe-Op acknowledged before the copy.");
  outputs_off_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    state != esm_pkg::ST_OP |=> outPins == '0)
    else $error("Outputs driven outside Op.");
  op_drive_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    state == esm_pkg::ST_OP |=> outPins == $past(masterOut))
    else $error("Outputs do not follow master data.");
  boot_entry_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(state == esm_pkg::ST_BOOT) |-> $past(state) == esm_pkg::ST_INIT)
    else $error("Bootstrap entered not from Init.");
  boot_gate_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    state == esm_pkg::ST_BOOT |-> foeOnly && !mbxEnable && !pdEnable)
    else $error("Wrong gates in Bootstrap.");
  same_fw_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    state == esm_pkg::ST_BOOT && fwDone && fwNewVer == fwVersion
    && !fwPending |=> !fwPending)
    else $error("Same firmware taken.");
  only_on_req_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !reqValid && phase == esm_pkg::PH_IDLE |=> $stable(state))
    else $error("State changed without a request.");
  fw_adopt_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    fwPending && state == esm_pkg::ST_INIT |=> fwAdopt ##1 !fwPending)
    else $error("Firmware not adopted in Init.");
  refused_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    illegal_req_s |=> $stable(state) && errFlag && ackValid)
    else $error("Refused request changed state.");
endmodule : slave_state_machine
`default_nettype wire

// ### verif/master_model.sv
// Purpose: Bus master model that sets up channels and requests states.
// Assumes: Requests change just after the falling clock edge.
// Notes: step returns the cycles from raising the request to the answer.
`timescale 1ns/10ps
`default_nettype none
module master_model (
  // Clock.
  input  wire logic       clk,
  // State request.
  output var  logic       reqValid,
  output var  logic [3:0] reqState,
  input  wire logic       ackValid,
  // Channel set-up results.
  output var  logic       mbxCfgOk,
  output var  logic       pdCfgOk
);
  initial
  begin
    reqValid = 1'b0;
    reqState = 4'h1;
    mbxCfgOk = 1'b0;
    pdCfgOk  = 1'b0;
  end

  // Sets up channels, raises one request and times its answer.
  task automatic step(input logic [3:0] code, input logic mbx,
                      input logic pd, output int lat);
    int n;
    n = 1;
    mbxCfgOk = mbx;
    pdCfgOk  = pd;
    reqValid = 1'b1;
    reqState = code;
    @(negedge clk);
    reqValid = 1'b0;
    reqState = ~code;
    while (ackValid !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    lat = n;
  endtask : step
endmodule : master_model
`default_nettype wire

// ### verif/slave_state_machine_tb.sv
// Purpose: Self-checking bench of the slave state machine.
// Assumes: Inputs change at the falling clock edge.
// Notes: Rows hold request, state, error code and check levels.
`timescale 1ns/10ps
`default_nettype none
module slave_state_machine_tb;
  localparam int DEPTH = 8;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reqValid, ackValid, errFlag, errClear, mbxCfgOk, pdCfgOk;
  logic        mbxEnable, foeOnly, pdEnable, fwDone, fwAdopt;
  logic [3:0]  reqState, curState, errCode, prev;
  logic [2:0]  inRdAddr;
  logic [15:0] inPins, inRdData, masterOut, outPins, fwNewVer, fwVersion;
  int          failures = 0;
  int          cmp_count = 0;
  int          adopts = 0;
  int          lat;
  logic [15:0] rows [9] = '{16'h8110, 16'h2120, 16'h2202, 16'h3212,
    16'h4232, 16'h4403, 16'h8803, 16'h1103, 16'h3303};

  always #5 clk = ~clk;

  master_model u_master (.clk(clk), .reqValid(reqValid),
    .reqState(reqState), .ackValid(ackValid), .mbxCfgOk(mbxCfgOk),
    .pdCfgOk(pdCfgOk));

  slave_state_machine #(.DEPTH(DEPTH)) u_dut (.clk(clk),
    .reset_n(reset_n), .reqValid(reqValid), .reqState(reqState),
    .curState(curState), .ackValid(ackValid), .errFlag(errFlag),
    .errCode(errCode), .errClear(errClear), .mbxCfgOk(mbxCfgOk),
    .pdCfgOk(pdCfgOk), .mbxEnable(mbxEnable), .foeOnly(foeOnly),
    .pdEnable(pdEnable), .inPins(inPins), .inRdAddr(inRdAddr),
    .inRdData(inRdData), .masterOut(masterOut), .outPins(outPins),
    .fwDone(fwDone), .fwNewVer(fwNewVer), .fwVersion(fwVersion),
    .fwAdopt(fwAdopt));

  always @(posedge clk)
    if (fwAdopt === 1'b1)
      adopts++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Expected gates as mailbox, file-access only, process data.
  function automatic logic [2:0] gates(input logic [3:0] s);
    case (s)
      4'h2: gates = 3'h4;
      4'h3: gates = 3'h2;
      4'h4, 4'h8: gates = 3'h5;
      default: gates = 3'h0;
    endcase
  endfunction : gates

  task automatic fw(input logic [15:0] ver);
    fwDone = 1'b1;
    fwNewVer = ver;
    @(negedge clk);
    fwDone = 1'b0;
  endtask : fw

  initial
  begin
    errClear = 1'b0;
    fwDone = 1'b0;
    fwNewVer = 16'h0;
    inPins = 16'h1234;
    inRdAddr = 3'h0;
    masterOut = 16'ha5c3;
    repeat (2) @(negedge clk);
    chk(curState, 4'h1);
    chk(outPins, 16'h0);
    reset_n = 1'b1;
    prev = 4'h1;
    foreach (rows[i])
    begin
      u_master.step(rows[i][15:12], rows[i][1], rows[i][0], lat);
      chk(16'(lat), (prev == 4'h2 && rows[i][11:8] == 4'h4) ? 9 : 1);
      chk(curState, rows[i][11:8]);
      chk(errCode, rows[i][7:4]);
      chk(errFlag, rows[i][7:4] != 4'h0);
      chk({mbxEnable, foeOnly, pdEnable}, gates(rows[i][11:8]));
      if (rows[i][11:8] == 4'h4 || rows[i][11:8] == 4'h8)
      begin
        chk(inRdData, inPins);
        inPins = inPins + 16'h0101;
        repeat (2) @(negedge clk);
        chk(inRdData, inPins);
      end
      errClear = 1'b1;
      @(negedge clk);
      errClear = 1'b0;
      chk(errFlag, 1'b0);
      chk(outPins, rows[i][11:8] == 4'h8 ? masterOut : 16'h0);
      prev = rows[i][11:8];
    end
    fw(16'h0000);
    u_master.step(4'h1, 1'b1, 1'b1, lat);
    repeat (2) @(negedge clk);
    chk(fwVersion, 16'h0);
    chk(16'(adopts), 16'h0);
    u_master.step(4'h3, 1'b1, 1'b1, lat);
    fw(16'h0102);
    u_master.step(4'h1, 1'b1, 1'b1, lat);
    repeat (5) @(negedge clk);
    chk(fwVersion, 16'h0102);
    chk(16'(adopts), 16'h1);
    chk(curState, 4'h1);
    u_master.step(4'h2, 1'b1, 1'b1, lat);
    chk(curState, 4'h2);
    reset_n = 1'b0;
    @(negedge clk);
    chk(curState, 4'h1);
    reset_n = 1'b1;
    final_report();
  end

  initial
  begin
    #100000;
    failures++;
    final_report();
  end
endmodule : slave_state_machine_tb
`default_nettype wire
